/* include/flash_host_pkg.sv */
// constants and types for the sector erase host controller
package flash_host_pkg;

  // register byte offsets on the avalon slave
  localparam logic [4:0] REG_CMD    = 5'h00;
  localparam logic [4:0] REG_SECTOR = 5'h04;
  localparam logic [4:0] REG_ADDR   = 5'h08;
  localparam logic [4:0] REG_WDATA  = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_RDATA  = 5'h14;

  // status register bit positions
  localparam int ST_MODE_LSB  = 0;
  localparam int ST_ENG_BUSY  = 4;
  localparam int ST_READY     = 5;
  localparam int ST_REFUSED   = 6;
  localparam int ST_ABORTED   = 7;
  localparam int ST_WIN_OPEN  = 8;

  // flash command addresses and codes (word mode)
  localparam logic [20:0] UNLOCK1_ADDR = 21'h00_0555;
  localparam logic [20:0] UNLOCK2_ADDR = 21'h00_02AA;
  localparam logic [20:0] ANY_ADDR     = 21'h00_0000;
  localparam logic [15:0] CODE_UNLOCK1 = 16'h00AA;
  localparam logic [15:0] CODE_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CODE_SETUP   = 16'h0080;
  localparam logic [15:0] CODE_SECTOR  = 16'h0030;
  localparam logic [15:0] CODE_RESUME  = 16'h0030;
  localparam logic [15:0] CODE_SUSPEND = 16'h00B0;
  localparam logic [15:0] CODE_RESET   = 16'h00F0;
  localparam logic [15:0] CODE_IDENT   = 16'h0090;
  localparam logic [15:0] CODE_PROGRAM = 16'h00A0;

  // timing, clock at 25 MHz
  localparam int CLK_KHZ        = 25000;
  localparam int WINDOW_US      = 50;
  localparam int SUSPEND_US     = 20;
  localparam int RESET_PULSE_NS = 500;
  localparam int WINDOW_CYC     = WINDOW_US * CLK_KHZ / 1000;
  localparam int SUSPEND_CYC    = (SUSPEND_US * CLK_KHZ + 999) / 1000;
  localparam int RESET_CYC      = (RESET_PULSE_NS * CLK_KHZ / 1000 + 999) / 1000;
  localparam logic [11:0] WINDOW_LIM  = 12'(WINDOW_CYC);
  localparam logic [11:0] SUSPEND_LIM = 12'(SUSPEND_CYC);
  localparam logic [11:0] RESET_LIM   = 12'(RESET_CYC);
  localparam logic [11:0] WE_LOW_LIM  = 12'h0002;
  localparam logic [11:0] READ_LIM    = 12'h0006;
  localparam logic [11:0] GUARD_LIM   = 12'h0008;

  // host orders written to the command register
  typedef enum logic [3:0] {
    OP_NONE    = 4'b0000,
    OP_ERASE   = 4'b0001,
    OP_ADD     = 4'b0010,
    OP_SUSPEND = 4'b0011,
    OP_RESUME  = 4'b0100,
    OP_READ    = 4'b0101,
    OP_PROGRAM = 4'b0110,
    OP_IDENT   = 4'b0111,
    OP_RESET   = 4'b1000,
    OP_HWRESET = 4'b1001
  } op_t;

  // tracked mode of the erasing bank
  typedef enum logic [3:0] {
    MODE_READ       = 4'b0000,
    MODE_WINDOW     = 4'b0001,
    MODE_ERASE      = 4'b0010,
    MODE_SUSPENDING = 4'b0011,
    MODE_SUSP       = 4'b0100,
    MODE_SUSP_PROG  = 4'b0101,
    MODE_IDENT      = 4'b0110,
    MODE_IDENT_SUSP = 4'b0111,
    MODE_PROG       = 4'b1000
  } mode_t;

  // bus cycle engine states
  typedef enum logic [2:0] {
    ENG_IDLE  = 3'b000,
    ENG_SETUP = 3'b001,
    ENG_WE    = 3'b010,
    ENG_HOLD  = 3'b011,
    ENG_RD    = 3'b100,
    ENG_RST   = 3'b101
  } eng_t;

  // one write cycle of a command sequence
  typedef struct packed {
    logic [20:0] addr;
    logic [15:0] data;
    logic        last;
  } step_t;

  // pins driven toward the flash
  typedef struct packed {
    logic [20:0] addr;
    logic [15:0] dout;
    logic        dq_oe_n;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        rst_n;
  } pins_t;

endpackage : flash_host_pkg

/* src/flash_host_ctrl.sv */
// host controller issuing sector erase, suspend and resume to a dual-bank flash
// Summary of operation
// R1: six-write erase sequence in fixed order
// R2: device preprograms itself, host sends nothing
// R3: device accepts added sectors during window
// R4: host adds sectors only inside window
// R5: additions go back to back, uninterrupted
// R6: other command in window resets bank
// R7: window timed from final write strobe
// R8: erase end returns bank to array read
// R9: erase progress visible on ready pin
// R10: during erase only suspend is sent
// R11: hardware reset aborts, sequence must restart
// R12: suspend is B0 to bank address
// R13: device ignores suspend during other operations
// R14: suspend settles within 20 us, window ends
// R15: suspended bank allows reads and programs
// R16: suspended sectors return status on reads
// R17: suspended program returns to suspended read
// R18: identification allowed while suspended
// R19: resume is 30 to bank, once
// R20: reset command leaves identification mode
// R21: polling bit zero while erasing
// R22: toggle bit stops on suspend
// R23: ready pin low while erasing or programming
// R24: bank mode tracked, commands checked against it
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
module flash_host_ctrl (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic [4:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  output flash_host_pkg::pins_t      flash_pins,
  input  wire logic [15:0]           dq_in,
  input  wire logic                  ready_busy_pin
);

  flash_host_pkg::eng_t  eng_q, eng_d;
  flash_host_pkg::mode_t mode_q, mode_d;
  flash_host_pkg::op_t   op_q;
  flash_host_pkg::pins_t pins_q, pins_d;
  flash_host_pkg::step_t step, pin_step;
  logic [2:0]  idx_q;
  logic [11:0] cnt_q;
  logic [11:0] win_q;
  logic [11:0] susp_q;
  logic [11:0] guard_q;
  logic [20:0] sector_q, addr_q;
  logic [15:0] wdata_q, rdata_q;
  logic [31:0] readdata_q;
  logic        rack_q, refused_q, aborted_q;
  logic [2:0]  rb_s;
  logic        rb_q;
  logic [15:0] dq_s1, dq_s2, dq_s3;

  // register decode
  wire       wr_cmd   = avs_write && avs_address == flash_host_pkg::REG_CMD;
  wire       wr_stat  = avs_write && avs_address == flash_host_pkg::REG_STATUS;
  wire       eng_idle = eng_q == flash_host_pkg::ENG_IDLE;
  wire       wr_ok    = avs_write && eng_idle;
  wire       new_op_v = avs_writedata[3:0] <= 4'h9;
  wire [3:0] new_op_b = new_op_v ? avs_writedata[3:0] : 4'h0;
  wire flash_host_pkg::op_t new_op = flash_host_pkg::op_t'(new_op_b);
  wire       win_open = mode_q == flash_host_pkg::MODE_WINDOW && win_q < flash_host_pkg::WINDOW_LIM;
  wire       guard_ok = guard_q == flash_host_pkg::GUARD_LIM;

  // legality of an order against the tracked bank mode
  wire legal_erase = mode_q == flash_host_pkg::MODE_READ;                       // see R1
  wire legal_add   = win_open;                                                  // see R4
  wire legal_susp  = mode_q == flash_host_pkg::MODE_WINDOW ||
                     mode_q == flash_host_pkg::MODE_ERASE;                      // see R12
  wire legal_res   = mode_q == flash_host_pkg::MODE_SUSP;                       // see R19
  wire legal_prog  = mode_q == flash_host_pkg::MODE_READ ||
                     mode_q == flash_host_pkg::MODE_SUSP;                       // see R15
  wire legal_ident = legal_prog;                                                // see R18
  wire legal_rst   = mode_q == flash_host_pkg::MODE_IDENT ||
                     mode_q == flash_host_pkg::MODE_IDENT_SUSP;                 // see R20
  wire legal =
    (new_op == flash_host_pkg::OP_ERASE   && legal_erase) ||
    (new_op == flash_host_pkg::OP_ADD     && legal_add)   ||
    (new_op == flash_host_pkg::OP_SUSPEND && legal_susp)  ||
    (new_op == flash_host_pkg::OP_RESUME  && legal_res)   ||
    (new_op == flash_host_pkg::OP_READ)                   ||
    (new_op == flash_host_pkg::OP_PROGRAM && legal_prog)  ||
    (new_op == flash_host_pkg::OP_IDENT   && legal_ident) ||
    (new_op == flash_host_pkg::OP_RESET   && legal_rst)   ||
    (new_op == flash_host_pkg::OP_HWRESET);              // see R6 see R10 see R24
  wire start   = wr_cmd && eng_idle && legal;
  wire refuse  = wr_cmd && eng_idle && !legal;

  // avalon handshake: commands and writes stall while the engine runs
  assign avs_waitrequest = (avs_write && !eng_idle) || (avs_read && !rack_q);
  assign avs_readdata    = readdata_q;

  // write sequence table for the current order
  function automatic flash_host_pkg::step_t step_of(
    input flash_host_pkg::op_t op,
    input logic [2:0]          idx,
    input logic [20:0]         sa,
    input logic [20:0]         pa,
    input logic [15:0]         pd
  );
    flash_host_pkg::step_t s;
    s = '{addr: sa, data: flash_host_pkg::CODE_SECTOR, last: 1'b1};
    unique case (op)
      flash_host_pkg::OP_ERASE, flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_IDENT: begin
        unique case (idx)
          3'd0, 3'd3: begin
            s = '{flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::CODE_UNLOCK1, 1'b0};
            if (op == flash_host_pkg::OP_PROGRAM && idx == 3'd3) s = '{pa, pd, 1'b1};  // data word
          end
          3'd1, 3'd4: s = '{flash_host_pkg::UNLOCK2_ADDR, flash_host_pkg::CODE_UNLOCK2, 1'b0};
          3'd2: begin
            s.addr = flash_host_pkg::UNLOCK1_ADDR;
            s.data = op == flash_host_pkg::OP_ERASE ? flash_host_pkg::CODE_SETUP :
                     op == flash_host_pkg::OP_IDENT ? flash_host_pkg::CODE_IDENT :
                     flash_host_pkg::CODE_PROGRAM;
            s.last = op == flash_host_pkg::OP_IDENT;
          end
          default: s = '{sa, flash_host_pkg::CODE_SECTOR, idx == 3'd5};
        endcase
      end
      flash_host_pkg::OP_SUSPEND: s.data = flash_host_pkg::CODE_SUSPEND;  // see R12
      flash_host_pkg::OP_RESUME:  s.data = flash_host_pkg::CODE_RESUME;   // see R19
      flash_host_pkg::OP_RESET:   s = '{flash_host_pkg::ANY_ADDR, flash_host_pkg::CODE_RESET, 1'b1};
      default:                    s.data = flash_host_pkg::CODE_SECTOR;   // added sector, see R3
    endcase
    return s;
  endfunction : step_of

  assign step = step_of(op_q, idx_q, sector_q, addr_q, wdata_q);  // see R1
  assign pin_step = eng_q == flash_host_pkg::ENG_IDLE ?
                    step_of(new_op, 3'd0, sector_q, addr_q, wdata_q) :
                    eng_q == flash_host_pkg::ENG_HOLD && !step.last ?
                    step_of(op_q, idx_q + 3'd1, sector_q, addr_q, wdata_q) : step;

  // engine phase ends
  wire cnt_done = cnt_q == 12'h000;
  wire seq_done = eng_q == flash_host_pkg::ENG_HOLD && step.last;
  wire rd_done  = eng_q == flash_host_pkg::ENG_RD && cnt_done;
  wire rst_done = eng_q == flash_host_pkg::ENG_RST && cnt_done;

  // engine next state
  always_comb begin
    eng_d = eng_q;
    unique case (eng_q)
      flash_host_pkg::ENG_IDLE: begin
        if (start) begin
          eng_d = new_op == flash_host_pkg::OP_READ    ? flash_host_pkg::ENG_RD :
                  new_op == flash_host_pkg::OP_HWRESET ? flash_host_pkg::ENG_RST :
                  flash_host_pkg::ENG_SETUP;
        end
      end
      flash_host_pkg::ENG_SETUP: eng_d = flash_host_pkg::ENG_WE;
      flash_host_pkg::ENG_WE:    eng_d = cnt_done ? flash_host_pkg::ENG_HOLD : flash_host_pkg::ENG_WE;
      flash_host_pkg::ENG_HOLD:  eng_d = step.last ? flash_host_pkg::ENG_IDLE : flash_host_pkg::ENG_SETUP;
      flash_host_pkg::ENG_RD:    eng_d = cnt_done ? flash_host_pkg::ENG_IDLE : flash_host_pkg::ENG_RD;
      flash_host_pkg::ENG_RST:   eng_d = cnt_done ? flash_host_pkg::ENG_IDLE : flash_host_pkg::ENG_RST;
      default:                   eng_d = flash_host_pkg::ENG_IDLE;
    endcase
  end

  // pin values for the coming cycle
  always_comb begin
    pins_d = '{addr: pins_q.addr, dout: pins_q.dout, dq_oe_n: 1'b1, ce_n: 1'b1,
               oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1};
    unique case (eng_d)
      flash_host_pkg::ENG_SETUP, flash_host_pkg::ENG_WE, flash_host_pkg::ENG_HOLD: begin
        pins_d.addr    = pin_step.addr;
        pins_d.dout    = pin_step.data;
        pins_d.dq_oe_n = 1'b0;
        pins_d.ce_n    = 1'b0;
        pins_d.we_n    = eng_d != flash_host_pkg::ENG_WE;
      end
      flash_host_pkg::ENG_RD: begin
        pins_d.addr = addr_q;
        pins_d.ce_n = 1'b0;
        pins_d.oe_n = 1'b0;
      end
      flash_host_pkg::ENG_RST: pins_d.rst_n = 1'b0;                         // see R11
      default: pins_d.ce_n = 1'b1;
    endcase
  end

  // bank mode tracking
  always_comb begin
    mode_d = mode_q;
    if (rst_done) begin
      mode_d = flash_host_pkg::MODE_READ;                                   // see R11
    end else if (seq_done) begin
      unique case (op_q)
        flash_host_pkg::OP_ERASE, flash_host_pkg::OP_ADD: mode_d = flash_host_pkg::MODE_WINDOW;
        flash_host_pkg::OP_SUSPEND: mode_d = mode_q == flash_host_pkg::MODE_WINDOW ?
                                    flash_host_pkg::MODE_SUSP : flash_host_pkg::MODE_SUSPENDING;
        flash_host_pkg::OP_RESUME:  mode_d = flash_host_pkg::MODE_ERASE;     // see R19
        flash_host_pkg::OP_PROGRAM: mode_d = mode_q == flash_host_pkg::MODE_SUSP ?
                                    flash_host_pkg::MODE_SUSP_PROG : flash_host_pkg::MODE_PROG;
        flash_host_pkg::OP_IDENT:   mode_d = mode_q == flash_host_pkg::MODE_SUSP ?
                                    flash_host_pkg::MODE_IDENT_SUSP : flash_host_pkg::MODE_IDENT;
        flash_host_pkg::OP_RESET:   mode_d = mode_q == flash_host_pkg::MODE_IDENT_SUSP ?
                                    flash_host_pkg::MODE_SUSP : flash_host_pkg::MODE_READ;  // see R20
        default:                    mode_d = mode_q;
      endcase
    end else if (mode_q == flash_host_pkg::MODE_WINDOW && !win_open) begin
      mode_d = flash_host_pkg::MODE_ERASE;                                  // see R7
    end else if (mode_q == flash_host_pkg::MODE_SUSPENDING && susp_q == flash_host_pkg::SUSPEND_LIM) begin
      mode_d = flash_host_pkg::MODE_SUSP;                                   // see R14
    end else if (guard_ok && rb_q) begin
      // ready pin released: erase or program finished
      if (mode_q == flash_host_pkg::MODE_ERASE || mode_q == flash_host_pkg::MODE_PROG) begin
        mode_d = flash_host_pkg::MODE_READ;                                 // see R8 see R9 see R23
      end else if (mode_q == flash_host_pkg::MODE_SUSP_PROG) begin
        mode_d = flash_host_pkg::MODE_SUSP;                                 // see R17
      end
    end
  end

  // engine, counters and pin registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eng_q  <= flash_host_pkg::ENG_IDLE;
      op_q   <= flash_host_pkg::OP_NONE;
      idx_q  <= 3'd0;
      cnt_q  <= 12'h000;
      pins_q <= '{addr: '0, dout: '0, dq_oe_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                  rst_n: 1'b1};
    end else begin
      eng_q  <= eng_d;
      pins_q <= pins_d;
      if (start) begin
        op_q  <= new_op;
        idx_q <= 3'd0;
      end else if (eng_q == flash_host_pkg::ENG_HOLD && !step.last) begin
        idx_q <= idx_q + 3'd1;                                              // see R5
      end
      if (eng_d == flash_host_pkg::ENG_WE && eng_q != flash_host_pkg::ENG_WE) begin
        cnt_q <= flash_host_pkg::WE_LOW_LIM - 12'h001;
      end else if (eng_d == flash_host_pkg::ENG_RD && eng_q == flash_host_pkg::ENG_IDLE) begin
        cnt_q <= flash_host_pkg::READ_LIM - 12'h001;
      end else if (eng_d == flash_host_pkg::ENG_RST && eng_q == flash_host_pkg::ENG_IDLE) begin
        cnt_q <= flash_host_pkg::RESET_LIM - 12'h001;
      end else if (!cnt_done) begin
        cnt_q <= cnt_q - 12'h001;
      end
    end
  end

  // mode, window timer, suspend wait and busy guard
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q  <= flash_host_pkg::MODE_READ;
      win_q   <= 12'h000;
      susp_q  <= 12'h000;
      guard_q <= 12'h000;
    end else begin
      mode_q  <= mode_d;
      win_q   <= seq_done ? 12'h000 : (win_open ? win_q + 12'h001 : win_q);  // see R7
      susp_q  <= mode_q == flash_host_pkg::MODE_SUSPENDING ? susp_q + 12'h001 : 12'h000;
      guard_q <= mode_d != mode_q ? 12'h000 : (guard_ok ? guard_q : guard_q + 12'h001);
    end
  end

  // pin synchronisers, change taken once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rb_s  <= 3'b111;
      rb_q  <= 1'b1;
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      dq_s3 <= 16'h0000;
    end else begin
      rb_s  <= {rb_s[1:0], ready_busy_pin};
      rb_q  <= rb_s[1] == rb_s[2] ? rb_s[2] : rb_q;
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // software registers and sticky flags, set wins over clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sector_q   <= '0;
      addr_q     <= '0;
      wdata_q    <= 16'h0000;
      rdata_q    <= 16'h0000;
      refused_q  <= 1'b0;
      aborted_q  <= 1'b0;
      rack_q     <= 1'b0;
      readdata_q <= 32'h0000_0000;
    end else begin
      if (wr_ok && avs_address == flash_host_pkg::REG_SECTOR) sector_q <= avs_writedata[20:0];
      if (wr_ok && avs_address == flash_host_pkg::REG_ADDR)   addr_q   <= avs_writedata[20:0];
      if (wr_ok && avs_address == flash_host_pkg::REG_WDATA)  wdata_q  <= avs_writedata[15:0];
      if (rd_done && dq_s2 == dq_s3) rdata_q <= dq_s3;                     // see R16 see R21 see R22
      refused_q <= refuse || (refused_q && !(wr_stat && avs_writedata[flash_host_pkg::ST_REFUSED]));
      aborted_q <= (start && new_op == flash_host_pkg::OP_HWRESET && mode_q != flash_host_pkg::MODE_READ) ||
                   (aborted_q && !(wr_stat && avs_writedata[flash_host_pkg::ST_ABORTED]));  // see R11
      rack_q    <= avs_read && !rack_q;
      if (avs_read && !rack_q) begin  // read data holds until the next read
        unique case (avs_address)
          flash_host_pkg::REG_CMD:    readdata_q <= {28'h000_0000, op_q};
          flash_host_pkg::REG_SECTOR: readdata_q <= {11'h000, sector_q};
          flash_host_pkg::REG_ADDR:   readdata_q <= {11'h000, addr_q};
          flash_host_pkg::REG_WDATA:  readdata_q <= {16'h0000, wdata_q};
          flash_host_pkg::REG_STATUS: readdata_q <= {23'h00_0000, win_open, aborted_q, refused_q,
                                                     rb_q, !eng_idle, mode_q};
          flash_host_pkg::REG_RDATA:  readdata_q <= {16'h0000, rdata_q};
          default:                    readdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign flash_pins = pins_q;

endmodule : flash_host_ctrl

/* test/flash_host_ctrl_assertions.sv */
// port checks for the sector erase host controller
module flash_host_checks (
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire logic                  avs_read,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire flash_host_pkg::pins_t flash_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // one write strobe: two cycles low, then high
  sequence we_pulse;
    !flash_pins.we_n [*2] ##1 flash_pins.we_n;
  endsequence

  // reset pulse of the fixed length
  sequence rst_pulse;
    ##12 !flash_pins.rst_n ##1 flash_pins.rst_n;
  endsequence

  we_width_a: assert property ($fell(flash_pins.we_n) |-> we_pulse)
    else $error("write strobe width wrong");
  we_in_ce_a: assert property (!flash_pins.we_n |-> !flash_pins.ce_n && flash_pins.oe_n)
    else $error("write strobe outside chip enable");
  we_stable_a: assert property ($fell(flash_pins.we_n) |-> $stable(flash_pins.addr))
    else $error("address moved at strobe start");
  rd_no_drive_a: assert property (!flash_pins.oe_n |-> flash_pins.dq_oe_n)
    else $error("data driven during read");
  rd_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait state wrong");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without read");
  hw_rst_len_a: assert property ($fell(flash_pins.rst_n) |-> rst_pulse)
    else $error("reset pulse length wrong");
  rst_quiet_a: assert property (!flash_pins.rst_n |-> flash_pins.we_n)
    else $error("write during reset pulse");
endmodule : flash_host_checks

bind flash_host_ctrl flash_host_checks flash_host_checks_i (
  .clk(clk), .nrst(nrst), .avs_read(avs_read), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .flash_pins(flash_pins));

/* test/flash_model.sv */
// behavioural flash bank: sector erase, window, suspend, resume
module flash_model #(
  parameter int ERASE_CYC = 3000,
  parameter int WIN_CYC   = 1250,
  parameter int SUSP_CYC  = 100
) (
  input  wire logic                  clk,
  input  wire flash_host_pkg::pins_t pins,
  output logic [15:0]                dq,
  output logic                       ready_busy_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int          md = 0;  // 0 read 1 window 2 erase 3 susp 4 susp prog 5 ident 6 suspending
  int          ul = 0, tmr = 0, ecnt = 0;
  logic [8:0]  sec = 9'h000;
  logic        we_q = 1'b1, oe_q = 1'b1, tog = 1'b0, tog2 = 1'b0, from_susp = 1'b0;
  logic [15:0] last = 16'h0000;
  wire  [7:0]  d    = pins.dout[7:0];
  wire  [11:0] a    = pins.addr[11:0];
  wire         ins  = pins.addr[20:12] == sec;
  wire         busy = md == 1 || md == 2 || md == 4 || md == 6;
  wire         stat = ins && md != 0 && md != 5;
  wire         drv  = !pins.ce_n && !pins.oe_n;
  wire  [15:0] val  = stat ? {8'h00, md == 3 || md == 4, tog, 2'b00, md != 1, tog2, 2'b00}
                           : pins.addr[15:0] ^ 16'hA5A5;

  // released lines show the inverse of the last value
  assign dq = drv ? val : ~last;
  assign ready_busy_pin = !busy;

  // command decode on the strobe's rising edge, timers otherwise
  always @(posedge clk) begin
    we_q <= pins.we_n;
    oe_q <= pins.oe_n;
    tmr  <= tmr + 1;
    if (drv) last <= val;
    if (pins.oe_n && !oe_q && stat) begin
      tog2 <= ~tog2;
      if (busy) tog <= ~tog;
    end
    if (!pins.rst_n) begin
      md <= 0;
      ul <= 0;
    end else if (pins.we_n && !we_q) begin
      tmr <= 0;
      if (md == 1) md <= d == 8'h30 ? 1 : d == 8'hB0 ? 3 : 0;
      else if (md == 2 && d == 8'hB0) md <= 6;
      else if (md == 3 && d == 8'h30 && ins) md <= 2;
      else if (md == 5 && d == 8'hF0) md <= from_susp ? 3 : 0;
      else if (md == 0 || md == 3) begin
        ul <= 0;
        case (ul)
          0: if (a == 12'h555 && d == 8'hAA) ul <= 1;
          1: if (a == 12'h2AA && d == 8'h55) ul <= 2;
          2: begin
            if (d == 8'h80 && md == 0) ul <= 3;
            if (d == 8'hA0) ul <= 6;
            if (d == 8'h90) md <= 5;
            from_susp <= md == 3;
          end
          3: if (d == 8'hAA) ul <= 4;
          4: if (d == 8'h55) ul <= 5;
          5: if (d == 8'h30) begin
            md   <= 1;
            sec  <= pins.addr[20:12];
            ecnt <= 0;
          end
          default: if (md == 3) md <= 4;
        endcase
      end
    end else begin
      if (md == 1 && tmr >= WIN_CYC) md <= 2;
      if (md == 2) ecnt <= ecnt + 1;
      if (md == 2 && ecnt >= ERASE_CYC) md <= 0;
      if (md == 6 && tmr >= SUSP_CYC || md == 4 && tmr >= 40) md <= 3;
    end
  end
endmodule : flash_model

/* test/tb.sv */
// self-checking bench for the sector erase host controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]            avs_address = 5'h00;
  logic [31:0]           avs_writedata = 32'h0000_0000, avs_readdata, st, r1;
  logic                  avs_waitrequest, ready_busy_pin;
  logic [15:0]           dq_in;
  flash_host_pkg::pins_t flash_pins;
  int                    bad_count = 0, n_tests = 0;

  flash_host_ctrl flash_host_ctrl_i (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flash_pins(flash_pins), .dq_in(dq_in), .ready_busy_pin(ready_busy_pin));
  flash_model flash_model_i (.clk(clk), .pins(flash_pins), .dq(dq_in),
    .ready_busy_pin(ready_busy_pin));

  // clock
  initial forever #20 clk = ~clk;

  // verdict and end of run
  task automatic test_done;
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  // compare one value
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // avalon transfer held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 4000);
    st = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      test_done;
    end
    @(posedge clk);
  endtask : bus

  // command register write
  task automatic op(input flash_host_pkg::op_t o);
    bus(1'b1, flash_host_pkg::REG_CMD, 32'(o));
  endtask : op

  // poll the mode field until it reaches m
  task automatic wait_mode(input logic [3:0] m, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      bus(1'b0, flash_host_pkg::REG_STATUS, 32'h0000_0000);
      if (st[3:0] === m) break;
    end
    chk("mode", st & 32'h0000_000F, 32'(m));
    if (k == lim) test_done;
  endtask : wait_mode

  // flash read; second address write stalls until the read is over
  task automatic frd(input logic [31:0] a);
    bus(1'b1, flash_host_pkg::REG_ADDR, a);
    op(flash_host_pkg::OP_READ);
    bus(1'b1, flash_host_pkg::REG_ADDR, a);
    bus(1'b0, flash_host_pkg::REG_RDATA, 32'h0000_0000);
  endtask : frd

  // refused flag check, then clear it
  task automatic refused(input logic [31:0] e);
    bus(1'b0, flash_host_pkg::REG_STATUS, 32'h0000_0000);
    chk("refused", st & 32'h0000_0040, e);
    bus(1'b1, flash_host_pkg::REG_STATUS, 32'h0000_0040);
  endtask : refused

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, flash_host_pkg::REG_STATUS, 32'h0000_0000);
    chk("status after reset", st, 32'h0000_0020);
    bus(1'b0, 5'h18, 32'h0000_0000);
    chk("unmapped", st, 32'h0000_0000);
    bus(1'b1, flash_host_pkg::REG_SECTOR, 32'h0000_2000);
    op(flash_host_pkg::OP_ERASE);
    wait_mode(4'h1, 20);
    chk("window open", st & 32'h0000_0100, 32'h0000_0100);
    frd(32'h0000_2010);
    chk("timer bit open", st & 32'h0000_0008, 32'h0000_0000);
    bus(1'b1, flash_host_pkg::REG_SECTOR, 32'h0000_5000);
    op(flash_host_pkg::OP_ADD);
    refused(32'h0000_0000);
    op(flash_host_pkg::OP_RESUME);
    refused(32'h0000_0040);
    bus(1'b1, flash_host_pkg::REG_SECTOR, 32'h0000_2000);
    wait_mode(4'h2, 600);
    frd(32'h0000_2010);
    r1 = st;
    frd(32'h0000_2010);
    chk("poll erasing", st & 32'h0000_0080, 32'h0000_0000);
    chk("toggle erasing", (st ^ r1) & 32'h0000_0040, 32'h0000_0040);
    chk("timer bit closed", st & 32'h0000_0008, 32'h0000_0008);
    frd(32'h0000_9000);
    chk("other bank", st, 32'h0000_35A5);
    op(flash_host_pkg::OP_PROGRAM);
    refused(32'h0000_0040);
    op(flash_host_pkg::OP_SUSPEND);
    wait_mode(4'h4, 200);
    chk("ready in suspend", st & 32'h0000_0020, 32'h0000_0020);
    frd(32'h0000_2010);
    r1 = st;
    frd(32'h0000_2010);
    chk("poll suspended", st & 32'h0000_0080, 32'h0000_0080);
    chk("toggle stopped", (st ^ r1) & 32'h0000_0040, 32'h0000_0000);
    bus(1'b1, flash_host_pkg::REG_ADDR, 32'h0000_9000);
    bus(1'b1, flash_host_pkg::REG_WDATA, 32'h0000_1234);
    op(flash_host_pkg::OP_PROGRAM);
    wait_mode(4'h5, 20);
    wait_mode(4'h4, 100);
    op(flash_host_pkg::OP_IDENT);
    wait_mode(4'h7, 20);
    op(flash_host_pkg::OP_RESET);
    wait_mode(4'h4, 20);
    op(flash_host_pkg::OP_RESUME);
    wait_mode(4'h2, 20);
    op(flash_host_pkg::OP_RESUME);
    refused(32'h0000_0040);
    wait_mode(4'h0, 2000);
    op(flash_host_pkg::OP_ERASE);
    wait_mode(4'h1, 20);
    op(flash_host_pkg::OP_SUSPEND);
    wait_mode(4'h4, 3);
    op(flash_host_pkg::OP_HWRESET);
    wait_mode(4'h0, 20);
    chk("aborted", st & 32'h0000_0080, 32'h0000_0080);
    test_done;
  end
endmodule : tb
